//--- logic/fnd_divider.sv
// fractional divide-by-n.f core: divider, phase accumulator, swallow gate, apb slave
//
// Behaviour
// RULE1: divider emits one pulse per programmed divisor of counted vco pulses
// RULE2: each divider pulse adds the fractional increment into the accumulator
// RULE3: accumulator starts at zero when division begins
// RULE4: overflow past one cycle subtracts one cycle, keeps remainder, deletes a pulse
// RULE5: sum exactly one cycle also overflows, leaving the accumulator at zero
// RULE6: the deleted pulse is the next vco pulse, never counted by the divider
// RULE7: accumulator value drives five interpolation bits, msd first, lsd last
// RULE8: interpolation bits carry decimal weights, ten times per step
// RULE9: zero fractional increment never swallows, plain integer division
// RULE10: divisor holds three decimal digits, fraction holds the next four
// RULE11: software keeps divisor within 420 to 704, fraction within 0000 to 9999
// RULE12: accumulator is four bcd digits, decimal carry out marks overflow
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module fnd_divider
   import fnd_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   input  wire logic                vco_sample,
   output var  logic                div_out_pulse,
   output var  logic                swallow_pulse,
   output var  logic [INTERP_W-1:0] phase_interp_switches
);
   // =====================================================================
   // declarations
   logic                 vco_meta_reg;
   logic                 vco_sync_reg;
   logic                 vco_prev_reg;
   logic                 vco_edge;
   logic                 enable_reg,   enable_next;
   logic [DIV_W-1:0]     divisor_reg,  divisor_next;
   fnd_bcd_type          fraction_reg, fraction_next;
   logic [31:0]          prdata_reg,   prdata_next;
   logic                 pslverr_reg,  pslverr_next;
   logic [DIV_W-1:0]     cnt_reg,      cnt_next;
   fnd_bcd_type          acc_reg,      acc_next;
   logic                 pend_reg,     pend_next;
   logic                 divp_reg,     divp_next;
   logic                 swp_reg,      swp_next;
   logic [INTERP_W-1:0]  interp_reg,   interp_next;
   logic [SWALLOW_W-1:0] swcount_reg,  swcount_next;
   logic                 apb_setup;
   logic                 apb_write;
   logic                 clear_swcount;

   fnd_bcd_if acc_bus ();

   fnd_bcd_adder u_adder
   (
      .bus (acc_bus.adder)
   );

   function automatic logic addr_mapped(input logic [11:0] a);
      return (a == ADDR_CTRL) || (a == ADDR_DIVISOR) || (a == ADDR_FRACTION)
             || (a == ADDR_STATUS) || (a == ADDR_SWALLOWS);
   endfunction

   // =====================================================================
   // vco pin synchroniser, edge taken only from the second stage
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         vco_meta_reg <= 1'b0;
         vco_sync_reg <= 1'b0;
         vco_prev_reg <= 1'b0;
      end
      else
      begin
         vco_meta_reg <= vco_sample;
         vco_sync_reg <= vco_meta_reg;
         vco_prev_reg <= vco_sync_reg;
      end
   end

   assign vco_edge = vco_sync_reg & ~vco_prev_reg;

   // =====================================================================
   // apb slave, zero wait states, read data captured in the setup cycle
   assign apb_setup     = psel & ~penable;
   assign apb_write     = psel & penable & pwrite & addr_mapped(paddr);
   assign clear_swcount = apb_write && (paddr == ADDR_SWALLOWS);

   always_comb
   begin
      enable_next   = enable_reg;
      divisor_next  = divisor_reg;
      fraction_next = fraction_reg;
      prdata_next   = prdata_reg;
      pslverr_next  = pslverr_reg;
      if (apb_setup)
      begin
         pslverr_next = ~addr_mapped(paddr);
         prdata_next  = READ_ZERO;
         if (!pwrite)
         begin
            unique case (paddr)
               ADDR_CTRL:     prdata_next[CTRL_ENABLE_BIT] = enable_reg;
               ADDR_DIVISOR:  prdata_next[DIV_W-1:0] = divisor_reg;
               ADDR_FRACTION: prdata_next[FRAC_W-1:0] = fraction_reg;
               ADDR_STATUS:
               begin
                  prdata_next[STATUS_ACC_LSB +: FRAC_W]      = acc_reg;
                  prdata_next[STATUS_INTERP_LSB +: INTERP_W] = interp_reg;
                  prdata_next[STATUS_PENDING_BIT]            = pend_reg;
               end
               ADDR_SWALLOWS: prdata_next[SWALLOW_W-1:0] = swcount_reg;
               default:       prdata_next = READ_ZERO;
            endcase
         end
      end
      if (apb_write)
      begin
         unique case (paddr)
            ADDR_CTRL:     enable_next = pwdata[CTRL_ENABLE_BIT];
            ADDR_DIVISOR:  divisor_next = pwdata[DIV_W-1:0]; // RULE10
            ADDR_FRACTION: fraction_next = pwdata[FRAC_W-1:0]; // RULE10
            default:       enable_next = enable_reg;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         enable_reg   <= 1'b0;
         divisor_reg  <= RESET_DIVISOR;
         fraction_reg <= RESET_FRACTION;
         prdata_reg   <= READ_ZERO;
         pslverr_reg  <= 1'b0;
      end
      else
      begin
         enable_reg   <= enable_next;
         divisor_reg  <= divisor_next;
         fraction_reg <= fraction_next;
         prdata_reg   <= prdata_next;
         pslverr_reg  <= pslverr_next;
      end
   end

   assign pready  = 1'b1;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // =====================================================================
   // divider, accumulator and swallow gate
   assign acc_bus.addend_a = acc_reg;
   assign acc_bus.addend_b = fraction_reg;

   always_comb
   begin
      cnt_next     = cnt_reg;
      acc_next     = acc_reg;
      pend_next    = pend_reg;
      divp_next    = 1'b0;
      swp_next     = 1'b0;
      swcount_next = clear_swcount ? {SWALLOW_W{1'b0}} : swcount_reg;
      if (!enable_reg)
      begin
         // held empty while stopped so a restart begins from zero
         cnt_next  = '0;
         acc_next  = '0; // RULE3
         pend_next = 1'b0;
      end
      else if (vco_edge)
      begin
         if (pend_reg)
         begin
            // pulse removed ahead of the divider, count left untouched
            pend_next    = 1'b0; // RULE6
            swp_next     = 1'b1; // RULE4
            swcount_next = swcount_next + 1'b1; // a swallow beats a clear
         end
         else if (cnt_reg + 10'h001 == divisor_reg)
         begin
            cnt_next  = '0; // RULE1
            divp_next = 1'b1;
            acc_next  = acc_bus.sum; // RULE2 RULE5
            pend_next = acc_bus.carry; // RULE4 RULE9 RULE12
         end
         else
         begin
            cnt_next = cnt_reg + 10'h001; // RULE1
         end
      end
      // top bit weighs one whole cycle, then tenths down to ten-thousandths
      interp_next[IDX_INTERP_BIT_MSD] = pend_next; // RULE7
      for (int d = 0; d < FRAC_DIGITS; d++)
      begin
         interp_next[d] = (acc_next[4*d +: 4] != 4'h0); // RULE8
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg     <= '0;
         acc_reg     <= '0;
         pend_reg    <= 1'b0;
         divp_reg    <= 1'b0;
         swp_reg     <= 1'b0;
         interp_reg  <= '0;
         swcount_reg <= '0;
      end
      else
      begin
         cnt_reg     <= cnt_next;
         acc_reg     <= acc_next;
         pend_reg    <= pend_next;
         divp_reg    <= divp_next;
         swp_reg     <= swp_next;
         interp_reg  <= interp_next;
         swcount_reg <= swcount_next;
      end
   end

   assign div_out_pulse         = divp_reg;
   assign swallow_pulse         = swp_reg;
   assign phase_interp_switches = interp_reg;

   // =====================================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic [DIV_W-1:0] seen_reg;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         seen_reg <= '0;
      else if (!enable_reg || divp_reg)
         seen_reg <= '0;
      else if (vco_edge && !pend_reg)
         seen_reg <= seen_reg + 10'h001;
   end

   sequence s_counted_edge;
      enable_reg && vco_edge && !pend_reg;
   endsequence

   sequence s_swallow_edge;
      enable_reg && vco_edge && pend_reg;
   endsequence

   AST_DIV_COUNT: assert property (s_counted_edge ##0 (seen_reg + 10'h001 == divisor_reg)
      |=> div_out_pulse && cnt_reg == '0) // RULE1
      else $error("divider did not fire after divisor counted pulses");

   AST_ACC_ADD: assert property (div_out_pulse |->
      fnd_bcd2int(acc_reg) == (fnd_bcd2int($past(acc_reg)) + fnd_bcd2int($past(fraction_reg)))
      % DECIMAL_WRAP) // RULE2
      else $error("accumulator did not add the increment");

   AST_START_ZERO: assert property (!enable_reg |=> acc_reg == '0 && !swallow_pulse) // RULE3
      else $error("accumulator not empty while stopped");

   AST_OVERFLOW: assert property (div_out_pulse && (fnd_bcd2int($past(acc_reg))
      + fnd_bcd2int($past(fraction_reg)) >= DECIMAL_WRAP) |-> pend_reg) // RULE4
      else $error("overflow did not arm a swallow");

   AST_EXACT_ONE: assert property (div_out_pulse && (fnd_bcd2int($past(acc_reg))
      + fnd_bcd2int($past(fraction_reg)) == DECIMAL_WRAP) |-> pend_reg && acc_reg == '0) // RULE5
      else $error("exact whole cycle not handled as overflow");

   AST_SWALLOW_NEXT: assert property (s_swallow_edge |=> swallow_pulse && !pend_reg
      && !div_out_pulse && $stable(cnt_reg)) // RULE6
      else $error("next vco pulse was not swallowed");

   AST_INTERP: assert property (##1 phase_interp_switches[IDX_INTERP_BIT_LSD]
      == (acc_reg[3:0] != 4'h0) && phase_interp_switches[IDX_INTERP_BIT_MSD] == pend_reg
      && phase_interp_switches[IDX_INTERP_BIT_MSD-1] == (acc_reg[15:12] != 4'h0)) // RULE7 RULE8
      else $error("interpolation bits disagree with accumulator");

   // a divider pulse with no fraction must never arm a swallow
   AST_NO_FRACTION: assert property ((fraction_reg == '0 && !pend_reg) ##1 div_out_pulse
      |-> !pend_reg) // RULE9
      else $error("swallow armed with zero fraction");

   AST_DIVISOR_LOAD: assert property (apb_write && paddr == ADDR_DIVISOR
      |=> divisor_reg == DIV_W'($past(pwdata))) // RULE10
      else $error("divisor write lost");
endmodule
`default_nettype wire

//--- logic/fnd_pkg.sv
// constants, types and helpers shared by the fractional divider files
`default_nettype none
package fnd_pkg;
   // =====================================================================
   // register map
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_DIVISOR  = 12'h004;
   localparam logic [11:0] ADDR_FRACTION = 12'h008;
   localparam logic [11:0] ADDR_STATUS   = 12'h00C;
   localparam logic [11:0] ADDR_SWALLOWS = 12'h010;

   // =====================================================================
   // field layout and widths
   localparam int DIV_W       = 10;
   localparam int FRAC_DIGITS = 4;
   localparam int FRAC_W      = 4 * FRAC_DIGITS;
   localparam int INTERP_W    = FRAC_DIGITS + 1;
   localparam int SWALLOW_W   = 16;
   localparam int CTRL_ENABLE_BIT     = 0;
   localparam int STATUS_ACC_LSB      = 0;
   localparam int STATUS_INTERP_LSB   = 16;
   localparam int STATUS_PENDING_BIT  = 21;
   localparam int IDX_INTERP_BIT_MSD  = INTERP_W - 1;
   localparam int IDX_INTERP_BIT_LSD  = 0;
   localparam int DECIMAL_WRAP        = 10000;

   // =====================================================================
   // reset values
   localparam logic [DIV_W-1:0]     RESET_DIVISOR  = 10'h207;
   localparam logic [FRAC_W-1:0]    RESET_FRACTION = 16'h0000;
   localparam logic [31:0]          READ_ZERO      = 32'h0000_0000;

   typedef logic [FRAC_W-1:0] fnd_bcd_type;

   // decimal value of a four digit bcd word
   function automatic int fnd_bcd2int(input fnd_bcd_type v);
      return int'(v[15:12]) * 1000 + int'(v[11:8]) * 100 + int'(v[7:4]) * 10 + int'(v[3:0]);
   endfunction
endpackage
`default_nettype wire

//--- logic/fnd_bcd_if.sv
// operands and result between the divider core and its bcd adder
`timescale 1ns/10ps
`default_nettype none
interface fnd_bcd_if;
   import fnd_pkg::*;
   fnd_bcd_type addend_a;
   fnd_bcd_type addend_b;
   fnd_bcd_type sum;
   logic        carry;
   modport user  (output addend_a, output addend_b, input sum, input carry);
   modport adder (input addend_a, input addend_b, output sum, output carry);
endinterface
`default_nettype wire

//--- logic/fnd_bcd_adder.sv
// four digit bcd adder with decimal carry out
`timescale 1ns/10ps
`default_nettype none
module fnd_bcd_adder
   import fnd_pkg::*;
(
   fnd_bcd_if.adder bus
);
   logic [FRAC_DIGITS:0] carry_chain;
   fnd_bcd_type          digit_sum;

   assign carry_chain[0] = 1'b0;

   // =====================================================================
   // digit ripple, carry out of the top digit is one whole vco cycle
   genvar i;
   for (i = 0; i < FRAC_DIGITS; i++)
   begin : g_digit
      logic [4:0] raw;
      assign raw = {1'b0, bus.addend_a[4*i+3:4*i]} + {1'b0, bus.addend_b[4*i+3:4*i]}
                   + {4'h0, carry_chain[i]};
      assign carry_chain[i+1] = (raw > 5'h09); // RULE12
      assign digit_sum[4*i+3:4*i] = carry_chain[i+1] ? 4'(raw - 5'h0A) : raw[3:0];
   end

   assign bus.sum   = digit_sum;
   assign bus.carry = carry_chain[FRAC_DIGITS]; // RULE12
endmodule
`default_nettype wire

//--- tb/fnd_vco_model.sv
// vco sample pulse source at the far side of the divider
`timescale 1ns/10ps
`default_nettype none
module fnd_vco_model
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic slow,
   output var  logic vco_sample
);
   int ph;
   // =============
   // pulse train
   // high and low two clocks or more, so the sync sees clean edges
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ph         <= 0;
         vco_sample <= 1'b0;
      end
      else if (ph != 0 || run)
      begin
         // a started pulse is always finished; idle level is low
         ph         <= (ph + 1) % (slow ? 6 : 4);
         vco_sample <= ph < (slow ? 3 : 2);
      end
   end
endmodule
`default_nettype wire

//--- tb/fractional_n_divider_accumulator_test.sv
// self-checking bench for the fractional divider
`timescale 1ns/10ps
`default_nettype none
module fractional_n_divider_accumulator_test;
   import fnd_pkg::*;
   logic                sys_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic                vco_sample, div_out_pulse, swallow_pulse, run, slow, er, pin_q;
   logic [INTERP_W-1:0] phase_interp_switches;
   logic [3:0]          dq, sq;
   logic [31:0]         s;
   int                  err_count, check_count, cyc, n, f, acc, cnt, pend, swc, divs, en;
   int                  tn[4] = '{519, 420, 704, 420};
   int                  tf[4] = '{3750, 0, 9999, 0};
   int                  td[4] = '{8, 3, 3, 4};

   fnd_divider i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .vco_sample(vco_sample), .div_out_pulse(div_out_pulse),
      .swallow_pulse(swallow_pulse), .phase_interp_switches(phase_interp_switches));
   fnd_vco_model i_vco (.sys_clk(sys_clk), .rst(rst), .run(run), .slow(slow),
      .vco_sample(vco_sample));

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // =============
   // helpers
   task automatic chk_pulse(input logic [1:0] got, input logic [1:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t div/swallow %b expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk_word(rd, e);
   endtask

   function automatic logic [15:0] to_bcd(input int v);
      return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction

   function automatic logic [31:0] status_exp();
      logic [15:0] b;
      b = to_bcd(acc);
      return {10'h000, pend != 0, pend != 0, |b[15:12], |b[11:8], |b[7:4], |b[3:0], b};
   endfunction

   task automatic complete_run;
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // =============
   // reference model, stepped on each pin rise; outputs lag three edges
   always @(negedge sys_clk)
   begin
      dq = {dq[2:0], 1'b0};
      sq = {sq[2:0], 1'b0};
      if (en != 0 && vco_sample === 1'b1 && pin_q === 1'b0)
      begin
         s = status_exp();
         chk_word({27'h000_0000, phase_interp_switches}, {27'h000_0000, s[20:16]});
         if (pend != 0)
         begin
            pend  = 0;
            sq[0] = 1'b1;
            swc++;
         end
         else
         begin
            cnt++;
            if (cnt == n)
            begin
               cnt   = 0;
               dq[0] = 1'b1;
               divs++;
               acc  += f;
               if (acc >= 10000)
               begin
                  acc -= 10000;
                  pend = 1;
               end
            end
         end
      end
      pin_q = vco_sample;
      chk_pulse({div_out_pulse, swallow_pulse}, {dq[3], sq[3]});
   end

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         err_count++;
         $display("[ERR] %0t timeout", $time);
         complete_run();
      end
   end

   task automatic run_case(input int cn, input int cf, input int cd, input int cs);
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      en = 0;
      apb(1'b1, ADDR_DIVISOR, 32'(cn));
      apb(1'b1, ADDR_FRACTION, {16'h0000, to_bcd(cf)});
      apb(1'b1, ADDR_SWALLOWS, 32'hFFFF_FFFF);
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
      n    = cn;
      f    = cf;
      acc  = 0;
      cnt  = 0;
      pend = 0;
      swc  = 0;
      divs = 0;
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      en = 1;
      slow <= cs[0];
      run  <= 1'b1;
      while (divs < cd)
         @(posedge sys_clk);
      run <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rd_chk(ADDR_STATUS, status_exp());
      rd_chk(ADDR_SWALLOWS, 32'(swc));
   endtask

   // =============
   // main sequence
   initial
   begin
      void'($urandom(32'hc9eb3f06));
      {rst, psel, penable, pwrite, run, slow, pin_q} = 7'h01 << 6;
      {paddr, pwdata, dq, sq} = '0;
      {err_count, check_count, cyc, en, n, f, acc, cnt, pend, swc, divs} = '0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk(ADDR_CTRL, 32'h0000_0000);
      rd_chk(ADDR_DIVISOR, {22'h00_0000, RESET_DIVISOR});
      rd_chk(ADDR_FRACTION, 32'h0000_0000);
      rd_chk(ADDR_STATUS, 32'h0000_0000);
      rd_chk(ADDR_SWALLOWS, 32'h0000_0000);
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk_word({rd[30:0], er}, 32'h0000_0001);
      tn[3] = 420 + $urandom % 285;
      tf[3] = $urandom % 10000;
      for (int i = 0; i < 4; i++)
         run_case(tn[i], tf[i], td[i], i % 2);
      complete_run();
   end
endmodule
`default_nettype wire
